/* inc/qdec_regs.vh */
// register map, fields and constants of the quadrature decoder
// Behaviour
// (R1) two channels, each 8-bit up/down counter
// (R2) inputs sampled on sample timer ticks
// (R3) sample tick at most half clk_sys
// (R4) channel inputs from upper or lower nibble
// (R5) in-phase odd bit, quadrature even bit
// (R6) enable/disable never causes a count
// (R7) filter rejects pulses under two samples
// (R8) timer fast enough: transitions sampled apart
// (R9) interrupt on zero crossing either direction
// (R10) flags set with interrupt; read clears both
// (R11) bit 7: channel 2 wrapped 0xff to 0x00
// (R12) bit 6: channel 2 wrapped 0x00 to 0xff
// (R13) bit 3: channel 1 wrapped 0xff to 0x00
// (R14) bit 2: channel 1 wrapped 0x00 to 0xff
// (R15) bits 5 and 1 read zero
// (R16) write 1 bit 4 clears channel 2
// (R17) write 1 bit 0 clears channel 1
// (R18) control bits 7:6 select channel 2 inputs
// (R19) control bits 3:2 select channel 1 inputs
// (R20) control bits 1:0 interrupt priority, 0 off
// (R21) count registers read counter values
// (R22) gray step counts up or down by one
// (R23) level passed after two equal samples
`ifndef QDEC_REGS_VH
`define QDEC_REGS_VH

// register indices; byte address is four times the index
`define QD_IDX_CSR        10'h090
`define QD_IDX_CTRL       10'h091
`define QD_IDX_CNT1       10'h094
`define QD_IDX_CNT2       10'h096
`define QD_IDX_TIMER      10'h098

// status/reset register fields
`define QD_CSR_CH2_UP     7
`define QD_CSR_CH2_DN     6
`define QD_CSR_CH2_CLR    4
`define QD_CSR_CH1_UP     3
`define QD_CSR_CH1_DN     2
`define QD_CSR_CH1_CLR    0

// control register fields
`define QD_CTRL_CH2_HI    7
`define QD_CTRL_CH2_LO    6
`define QD_CTRL_CH1_HI    3
`define QD_CTRL_CH1_LO    2
`define QD_CTRL_PRIO_HI   1
`define QD_CTRL_PRIO_LO   0
`define QD_CTRL_MASK      8'hcf

// port bit positions for each selection
`define QD_CH1_LO_I       1
`define QD_CH1_LO_Q       0
`define QD_CH1_HI_I       5
`define QD_CH1_HI_Q       4
`define QD_CH2_LO_I       3
`define QD_CH2_LO_Q       2
`define QD_CH2_HI_I       7
`define QD_CH2_HI_Q       6

// reset values and limits
`define QD_CTRL_RST       8'h00
`define QD_TIMER_RST      8'h01
`define QD_TIMER_MIN      8'h01
`define QD_CNT_ZERO       8'h00
`define QD_CNT_ONE        8'h01
`define QD_CNT_FULL       8'hff

`endif

/* design/qdec_channel.v */
// one decoder channel: two-sample filter, gray decode, 8-bit counter
`timescale 1ns/1ps
`include "qdec_regs.vh"
module qdec_channel #(
	parameter CNT_W = 8
) (
	input  wire             clk_sys,
	input  wire             rst_n,
	input  wire             tick,
	input  wire             enable,
	input  wire             resync,
	input  wire             i_in,
	input  wire             q_in,
	input  wire             clr,
	output reg  [CNT_W-1:0] count_r,
	output reg              up_wrap_r,
	output reg              dn_wrap_r,
	output reg              up_zero_r
);
	reg  [1:0] samp_r;
	reg  [1:0] filt_r;
	reg        sync_pend_r;
	wire [1:0] raw      = {i_in, q_in};
	wire       stable   = (raw == samp_r);
	wire [1:0] diff     = stable ? (raw ^ filt_r) : 2'b00;
	wire       one_step = (diff == 2'b01) || (diff == 2'b10);
	wire       go_up    = raw[1] ^ filt_r[0];
	wire       step     = tick && enable && !sync_pend_r && one_step;
	wire [CNT_W-1:0] zero_v = {CNT_W{1'b0}};
	wire [CNT_W-1:0] full_v = {CNT_W{1'b1}};
	wire [CNT_W-1:0] one_v  = {{(CNT_W-1){1'b0}}, 1'b1};

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			samp_r      <= 2'b00;
			filt_r      <= 2'b00;
			sync_pend_r <= 1'b1;
			count_r     <= {CNT_W{1'b0}};
			up_wrap_r   <= 1'b0;
			dn_wrap_r   <= 1'b0;
			up_zero_r   <= 1'b0;
		end else begin
			up_wrap_r <= 1'b0;
			dn_wrap_r <= 1'b0;
			up_zero_r <= 1'b0;
			if (tick)
				samp_r <= raw; // [R2]
			// disabled or reselected: relearn level without counting
			if (!enable || resync)
				sync_pend_r <= 1'b1; // [R6]
			else if (tick && stable && sync_pend_r) begin
				filt_r      <= raw; // [R6]
				sync_pend_r <= 1'b0;
			end else if (tick && stable)
				filt_r <= raw; // [R7] [R23]
			if (clr)
				count_r <= zero_v; // [R16] [R17]
			else if (step && go_up) begin
				count_r   <= count_r + one_v; // [R22] [R1]
				up_wrap_r <= (count_r == full_v); // [R11] [R13]
				up_zero_r <= (count_r == zero_v); // [R9]
			end else if (step) begin
				count_r   <= count_r - one_v; // [R22] [R1]
				dn_wrap_r <= (count_r == zero_v); // [R9] [R12] [R14]
			end
		end
	end
endmodule // qdec_channel

/* design/qdec_top.v */
// two-channel quadrature decoder with apb register slave
`timescale 1ns/1ps
`include "qdec_regs.vh"
module qdec_top #(
	parameter CNT_W = 8
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [7:0]  port_in,
	output reg         qd_irq_r,
	output reg  [1:0]  qd_irq_prio_r
);
	// apb decode
	wire [9:0] idx       = paddr[11:2];
	wire       hit_csr   = (idx == `QD_IDX_CSR);
	wire       hit_ctrl  = (idx == `QD_IDX_CTRL);
	wire       hit_cnt1  = (idx == `QD_IDX_CNT1);
	wire       hit_cnt2  = (idx == `QD_IDX_CNT2);
	wire       hit_timer = (idx == `QD_IDX_TIMER);
	wire       mapped    = hit_csr | hit_ctrl | hit_cnt1 | hit_cnt2 |
	                       hit_timer;
	wire       access    = psel && penable;
	// completion edge: access phase with pready already high
	wire       done      = access && pready;
	wire       wr_done   = done && pwrite && mapped && pstrb[0];
	wire       rd_csr    = done && !pwrite && hit_csr;

	reg  [7:0] ctrl_r;
	reg  [7:0] timer_reload_r;
	reg  [7:0] timer_cnt_r;
	reg        tick_r;
	reg  [3:0] flags_r;
	reg  [3:0] flags_seen_r;
	reg        irq_pend_r;
	reg        irq_seen_r;
	reg        resync1_r;
	reg        resync2_r;

	wire [CNT_W-1:0] cnt1;
	wire [CNT_W-1:0] cnt2;
	wire             ch1_up;
	wire             ch1_dn;
	wire             ch1_z;
	wire             ch2_up;
	wire             ch2_dn;
	wire             ch2_z;

	// channel input routing
	wire ch1_en = ctrl_r[`QD_CTRL_CH1_HI]; // [R19] [R6]
	wire ch2_en = ctrl_r[`QD_CTRL_CH2_HI]; // [R18] [R6]
	wire ch1_i  = ctrl_r[`QD_CTRL_CH1_LO] ? port_in[`QD_CH1_HI_I]
	                                      : port_in[`QD_CH1_LO_I]; // [R4] [R5]
	wire ch1_q  = ctrl_r[`QD_CTRL_CH1_LO] ? port_in[`QD_CH1_HI_Q]
	                                      : port_in[`QD_CH1_LO_Q]; // [R4] [R5]
	wire ch2_i  = ctrl_r[`QD_CTRL_CH2_LO] ? port_in[`QD_CH2_HI_I]
	                                      : port_in[`QD_CH2_LO_I]; // [R4] [R5]
	wire ch2_q  = ctrl_r[`QD_CTRL_CH2_LO] ? port_in[`QD_CH2_HI_Q]
	                                      : port_in[`QD_CH2_LO_Q]; // [R4] [R5]

	wire clr1 = wr_done && hit_csr && pwdata[`QD_CSR_CH1_CLR]; // [R17]
	wire clr2 = wr_done && hit_csr && pwdata[`QD_CSR_CH2_CLR]; // [R16]

	// events in status bit order {ch2 up, ch2 dn, ch1 up, ch1 dn}
	wire [3:0] ev_flags = {ch2_up, ch2_dn, ch1_up, ch1_dn};
	wire       ev_any   = |ev_flags | ch1_z | ch2_z;

	wire [7:0] csr_view;
	assign csr_view = {flags_r[3], flags_r[2], 1'b0, 1'b0,
	                   flags_r[1], flags_r[0], 1'b0, 1'b0}; // [R15]

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		if (hit_csr)
			rd_mux = {24'h000000, csr_view}; // [R11] [R12] [R13] [R14]
		else if (hit_ctrl)
			rd_mux = {24'h000000, ctrl_r};
		else if (hit_cnt1)
			rd_mux = {24'h000000, cnt1}; // [R21]
		else if (hit_cnt2)
			rd_mux = {24'h000000, cnt2}; // [R21]
		else if (hit_timer)
			rd_mux = {24'h000000, timer_reload_r};
	end

	// apb slave: one wait state, answer registered
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready       <= 1'b0;
			prdata       <= 32'h0000_0000;
			pslverr      <= 1'b0;
			flags_seen_r <= 4'h0;
			irq_seen_r   <= 1'b0;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !mapped;
			if (access && !pready) begin
				prdata       <= pwrite ? 32'h0000_0000 : rd_mux;
				flags_seen_r <= (!pwrite && hit_csr) ? flags_r : 4'h0;
				irq_seen_r   <= !pwrite && hit_csr && irq_pend_r;
			end
		end
	end

	// control, sample timer reload
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r         <= `QD_CTRL_RST;
			timer_reload_r <= `QD_TIMER_RST;
			resync1_r      <= 1'b0;
			resync2_r      <= 1'b0;
		end else begin
			resync1_r <= 1'b0;
			resync2_r <= 1'b0;
			if (wr_done && hit_ctrl) begin
				ctrl_r    <= pwdata[7:0] & `QD_CTRL_MASK; // [R18] [R19] [R20]
				// nibble swap must relearn the level, not count it
				resync1_r <= (pwdata[`QD_CTRL_CH1_LO] !=
				              ctrl_r[`QD_CTRL_CH1_LO]); // [R6]
				resync2_r <= (pwdata[`QD_CTRL_CH2_LO] !=
				              ctrl_r[`QD_CTRL_CH2_LO]); // [R6]
			end
			if (wr_done && hit_timer)
				timer_reload_r <= (pwdata[7:0] < `QD_TIMER_MIN) ?
				                  `QD_TIMER_MIN : pwdata[7:0]; // [R3]
		end
	end

	// sample clock timer: one tick every reload+1 cycles
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_cnt_r <= `QD_TIMER_RST;
			tick_r      <= 1'b0;
		end else if (timer_cnt_r == 8'h00) begin
			timer_cnt_r <= timer_reload_r; // [R3]
			tick_r      <= 1'b1; // [R2]
		end else begin
			timer_cnt_r <= timer_cnt_r - 8'h01;
			tick_r      <= 1'b0;
		end
	end

	// sticky flags: set wins over clear-on-read
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flags_r       <= 4'h0;
			irq_pend_r    <= 1'b0;
			qd_irq_r      <= 1'b0;
			qd_irq_prio_r <= 2'b00;
		end else begin
			if (rd_csr)
				flags_r <= (flags_r & ~flags_seen_r) | ev_flags; // [R10]
			else
				flags_r <= flags_r | ev_flags; // [R10]
			if (rd_csr && irq_seen_r && !ev_any)
				irq_pend_r <= 1'b0; // [R10]
			else if (ev_any)
				irq_pend_r <= 1'b1; // [R9]
			qd_irq_r      <= irq_pend_r &&
			                 (ctrl_r[`QD_CTRL_PRIO_HI:`QD_CTRL_PRIO_LO]
			                  != 2'b00); // [R20]
			qd_irq_prio_r <= ctrl_r[`QD_CTRL_PRIO_HI:`QD_CTRL_PRIO_LO];
		end
	end

	qdec_channel #(
		.CNT_W (CNT_W)
	) u_ch1 (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tick      (tick_r),
		.enable    (ch1_en),
		.resync    (resync1_r),
		.i_in      (ch1_i),
		.q_in      (ch1_q),
		.clr       (clr1),
		.count_r   (cnt1),
		.up_wrap_r (ch1_up),
		.dn_wrap_r (ch1_dn),
		.up_zero_r (ch1_z)
	);

	qdec_channel #(
		.CNT_W (CNT_W)
	) u_ch2 (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tick      (tick_r),
		.enable    (ch2_en),
		.resync    (resync2_r),
		.i_in      (ch2_i),
		.q_in      (ch2_q),
		.clr       (clr2),
		.count_r   (cnt2),
		.up_wrap_r (ch2_up),
		.dn_wrap_r (ch2_dn),
		.up_zero_r (ch2_z)
	);
endmodule // qdec_top

/* dv/qdec_chk.sv */
// assertions on the decoder's apb and interrupt ports
`timescale 1ns/1ps
module qdec_chk (
	input logic        clk_sys,
	input logic        rst_n,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0]  pstrb,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        qd_irq_r,
	input logic [1:0]  qd_irq_prio_r
);
	logic       done;
	logic       mapped;
	logic       wr_ctrl;
	logic [1:0] wd_r;
	assign done = psel && penable && pready;
	assign mapped = paddr[11:2] inside
		{10'h090, 10'h091, 10'h094, 10'h096, 10'h098};
	assign wr_ctrl = done && pwrite && pstrb[0] && paddr == 12'h244;
	always @(posedge clk_sys)
		if (wr_ctrl)
			wd_r <= pwdata[1:0];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	chk_ready_wait: assert property (s_setup ##1 s_wait |=> pready)
		else $error("pready late");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_unmapped: assert property (done && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	chk_ok_mapped: assert property (done && mapped |-> !pslverr)
		else $error("error on mapped address");
	chk_high_zero: assert property (
		done && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_csr_zero: assert property (
		done && !pwrite && paddr == 12'h240 |->
		prdata[5:4] == 2'h0 && prdata[1:0] == 2'h0)
		else $error("status zero bits set");
	chk_prio_copy: assert property (
		wr_ctrl |=> ##[0:1] qd_irq_prio_r == wd_r)
		else $error("priority not copied");
	chk_irq_prio: assert property (
		qd_irq_prio_r == 2'h0 [*2] |-> !qd_irq_r)
		else $error("interrupt while disabled");
endmodule // qdec_chk

bind qdec_top qdec_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .qd_irq_r(qd_irq_r), .qd_irq_prio_r(qd_irq_prio_r));

/* dv/qdec_enc_model.sv */
// two incremental encoders driving the decoder input port
`timescale 1ns/1ps
module qdec_enc_model (
	input  logic       clk_sys,
	input  logic [1:0] step,
	input  logic [1:0] dir,
	input  logic [1:0] hi,
	input  logic       glitch,
	output logic [7:0] port_in
);
	logic [1:0] ph0 = 2'h0;
	logic [1:0] ph1 = 2'h0;
	// one gray step per request, spaced by the bench
	always @(posedge clk_sys) begin
		if (step[0])
			ph0 <= dir[0] ? ph0 + 2'h1 : ph0 - 2'h1;
		if (step[1])
			ph1 <= dir[1] ? ph1 + 2'h1 : ph1 - 2'h1;
	end
	// in-phase on the odd bit, quadrature on the even bit
	always_comb begin
		port_in = 8'h00;
		port_in[{hi[0], 2'h0} +: 2] = {ph0[0] ^ ph0[1] ^ glitch, ph0[1]};
		port_in[{hi[1], 2'h2} +: 2] = {ph1[0] ^ ph1[1], ph1[1]};
	end
endmodule // qdec_enc_model

/* dv/test_quadrature_decoder_two_channel.sv */
// bench for the two-channel quadrature decoder
`timescale 1ns/1ps
module test_quadrature_decoder_two_channel;
	logic        clk_sys = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        qd_irq_r;
	logic        glitch = 1'h0;
	logic [1:0]  qd_irq_prio_r;
	logic [1:0]  step = 2'h0;
	logic [1:0]  dir = 2'h0;
	logic [1:0]  hi = 2'h2;
	logic [7:0]  port_in;
	int          n_mismatch = 0;
	int          checked = 0;
	qdec_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_in(port_in), .qd_irq_r(qd_irq_r), .qd_irq_prio_r(qd_irq_prio_r));
	qdec_enc_model enc (.clk_sys(clk_sys), .step(step), .dir(dir),
		.hi(hi), .glitch(glitch), .port_in(port_in));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic close_out;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, s);
		checked++;
		if (s !== e) begin
			$display("wrong value %s exp %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] r, output logic er);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 40);
		r = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 40) begin
			n_mismatch++;
			close_out;
		end
		@(posedge clk_sys);
	endtask
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [7:0] e);
		logic [31:0] r;
		logic        er;
		apb(1'h0, a, 8'h00, r, er);
		cmp(nm, {24'h0, e}, r);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        er;
		apb(1'h1, a, d, r, er);
	endtask
	task automatic irq(input logic e);
		repeat (2) @(posedge clk_sys);
		cmp("irq", {31'h0, e}, {31'h0, qd_irq_r});
	endtask
	task automatic mv(input int c, input logic up, input int n);
		repeat (n) begin
			step[c] <= 1'h1;
			dir[c] <= up;
			@(posedge clk_sys);
			step[c] <= 1'h0;
			repeat (12) @(posedge clk_sys);
		end
	endtask
	task automatic t_reset;
		logic [31:0] r;
		logic        er;
		rd("ctrl", 12'h244, 8'h00);
		rd("csr", 12'h240, 8'h00);
		rd("cnt1", 12'h250, 8'h00);
		rd("cnt2", 12'h258, 8'h00);
		rd("timer", 12'h260, 8'h01);
		wr(12'h260, 8'h00);
		rd("timer", 12'h260, 8'h01);
		apb(1'h0, 12'h200, 8'h00, r, er);
		cmp("unmapped", 32'h1, {31'h0, er});
	endtask
	task automatic t_ch1;
		wr(12'h244, 8'h09);
		rd("ctrl", 12'h244, 8'h09);
		mv(0, 1'h1, 1);
		rd("cnt1", 12'h250, 8'h01);
		irq(1'h1);
		rd("csr", 12'h240, 8'h00);
		irq(1'h0);
		mv(0, 1'h0, 2);
		rd("cnt1", 12'h250, 8'hff);
		irq(1'h1);
		rd("csr", 12'h240, 8'h04);
		rd("csr", 12'h240, 8'h00);
		mv(0, 1'h1, 3);
		rd("csr", 12'h240, 8'h08);
		rd("cnt1", 12'h250, 8'h02);
	endtask
	task automatic t_ch2;
		wr(12'h244, 8'hc2);
		mv(0, 1'h1, 1);
		wr(12'h244, 8'hca);
		repeat (12) @(posedge clk_sys);
		rd("cnt1", 12'h250, 8'h02);
		mv(1, 1'h0, 1);
		rd("csr", 12'h240, 8'h40);
		mv(1, 1'h1, 4);
		rd("csr", 12'h240, 8'h80);
		rd("cnt2", 12'h258, 8'h03);
		wr(12'h240, 8'h10);
		rd("cnt2", 12'h258, 8'h00);
		rd("cnt1", 12'h250, 8'h02);
		irq(1'h0);
		wr(12'h240, 8'h01);
		rd("cnt1", 12'h250, 8'h00);
	endtask
	task automatic t_glitch;
		glitch <= 1'h1;
		repeat (2) @(posedge clk_sys);
		glitch <= 1'h0;
		repeat (12) @(posedge clk_sys);
		rd("cnt1", 12'h250, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
		@(posedge clk_sys);
		t_reset;
		t_ch1;
		t_ch2;
		t_glitch;
		close_out;
	end
endmodule // test_quadrature_decoder_two_channel
